//--- hdl/tig_consts.svh
`ifndef TIG_CONSTS_SVH
`define TIG_CONSTS_SVH

// Register offsets on the serial port's internal register path
`define TIG_ADDR_DRV_ON    8'h01
`define TIG_ADDR_BLK_IEN   8'h20
`define TIG_ADDR_BLK_ISTAT 8'h21

// Field positions of the driver-on register
`define TIG_DRV_CH0_BIT    0
`define TIG_DRV_CH1_BIT    1

// Reset values
`define TIG_DRV_ON_RST     2'h0
`define TIG_BLK_IEN_RST    8'h00
`define TIG_BLK_ISTAT_RST  8'h00

`endif

//--- hdl/tig_pkg.sv
package tig_pkg;

    // One access from the serial port's register front end
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tig_reg_req_t;

endpackage

//--- hdl/tig_top.sv
// Behaviour
// R1 - Driver-on bit 1 enables channel 1 driver
// R2 - Driver-on bit 0 enables channel 0 driver
// R3 - Hardware enable pin must be high
// R4 - Block interrupt enable at 0x20, bits 2:0
// R5 - Disabled channel raises no interrupt at all
// R6 - Source needs source and block enable set
// R7 - Every channel bit gates its own channel
// R8 - Pending bit stays until source status read
// R9 - Request output follows any pending enabled channel
`timescale 1ns/1ps
`include "tig_consts.svh"
module tig_top
    import tig_pkg::*;
#(
    parameter int NCH = 3
) (
    input  wire logic            clk_in,
    input  wire logic            rst_b_in,
    input  wire tig_reg_req_t    reg_req_in,
    output logic [7:0]           reg_rdata_out,
    input  wire logic            hw_driver_enable_pin_ch0_in,
    input  wire logic            hw_driver_enable_pin_ch1_in,
    input  wire logic [1:0]      tx_pos_in,
    input  wire logic [1:0]      tx_neg_in,
    output logic                 line_out_pos_ch0_out,
    output logic                 line_out_pos_ch0_oe_b_out,
    output logic                 line_out_neg_ch0_out,
    output logic                 line_out_neg_ch0_oe_b_out,
    output logic                 line_out_pos_ch1_out,
    output logic                 line_out_pos_ch1_oe_b_out,
    output logic                 line_out_neg_ch1_out,
    output logic                 line_out_neg_ch1_oe_b_out,
    input  wire logic [NCH-1:0]  src_event_in,
    input  wire logic [NCH-1:0]  src_enable_in,
    input  wire logic [NCH-1:0]  src_status_read_in,
    output logic                 irq_out
);

    // Channel count sets field widths in 8-bit registers
    if (NCH < 1 || NCH > 8) begin : g_bad_nch
        $error("tig_top: NCH must be 1 to 8");
    end

    // Register, synchroniser and output state
    logic [1:0]     drv_q;
    logic [1:0]     drv_d;
    logic [NCH-1:0] ien_q;
    logic [NCH-1:0] ien_d;
    logic [NCH-1:0] pend_q;
    logic [NCH-1:0] pend_d;
    logic [7:0]     rdata_q;
    logic [7:0]     rdata_d;
    logic [1:0]     pin_s1_q;
    logic [1:0]     pin_s2_q;
    logic [1:0]     pos_q;
    logic [1:0]     neg_q;
    logic [1:0]     oe_b_q;
    logic           irq_q;

    // True when the request targets the given offset
    function automatic logic hit(input tig_reg_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    // Address decode
    wire wr_drv  = reg_req_in.wr && hit(reg_req_in, `TIG_ADDR_DRV_ON);
    wire wr_ien  = reg_req_in.wr && hit(reg_req_in, `TIG_ADDR_BLK_IEN);
    wire rd_drv  = reg_req_in.rd && hit(reg_req_in, `TIG_ADDR_DRV_ON);
    wire rd_ien  = reg_req_in.rd && hit(reg_req_in, `TIG_ADDR_BLK_IEN);
    wire rd_stat = reg_req_in.rd && hit(reg_req_in, `TIG_ADDR_BLK_ISTAT);

    // Driver live only with register bit and pin both high
    wire [1:0] drv_act = drv_q & pin_s2_q; // see R1 see R2 see R3

    // Gated interrupt set: source enable and block enable
    wire [NCH-1:0] pend_set = src_event_in & src_enable_in & ien_q; // see R6
    wire [NCH-1:0] pend_hot = pend_q & ien_q; // see R5 see R7

    // Register and pending next values; set beats clear
    assign drv_d  = wr_drv ? reg_req_in.wdata[1:0] : drv_q; // see R1 see R2
    assign ien_d  = wr_ien ? reg_req_in.wdata[NCH-1:0] : ien_q; // see R4
    assign pend_d = pend_set | (pend_q & ~src_status_read_in); // see R8
    assign rdata_d = rd_drv  ? {6'h00, drv_q} :
                     rd_ien  ? 8'({ien_q}) :     // see R4
                     rd_stat ? 8'({pend_q}) :
                     reg_req_in.rd ? 8'h00 : rdata_q;

    // Control registers
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            drv_q   <= `TIG_DRV_ON_RST;
            ien_q   <= NCH'(`TIG_BLK_IEN_RST);
            pend_q  <= NCH'(`TIG_BLK_ISTAT_RST);
            rdata_q <= 8'h00;
        end else begin
            drv_q   <= drv_d;
            ien_q   <= ien_d;
            pend_q  <= pend_d;
            rdata_q <= rdata_d;
        end
    end

    // Pin synchroniser; the enable pins are asynchronous
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pin_s1_q <= 2'h0;
            pin_s2_q <= 2'h0;
        end else begin
            pin_s1_q <= {hw_driver_enable_pin_ch1_in,
                         hw_driver_enable_pin_ch0_in};
            pin_s2_q <= pin_s1_q;
        end
    end

    // Line outputs; data held low while tri-stated
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pos_q  <= 2'h0;
            neg_q  <= 2'h0;
            oe_b_q <= 2'h3;
            irq_q  <= 1'b0;
        end else begin
            pos_q  <= tx_pos_in & drv_act;
            neg_q  <= tx_neg_in & drv_act;
            oe_b_q <= ~drv_act; // see R1 see R2
            irq_q  <= |pend_hot; // see R9
        end
    end

    // Outputs straight from flops; both legs share one enable
    assign reg_rdata_out             = rdata_q;
    assign line_out_pos_ch0_out      = pos_q[`TIG_DRV_CH0_BIT];
    assign line_out_neg_ch0_out      = neg_q[`TIG_DRV_CH0_BIT];
    assign line_out_pos_ch1_out      = pos_q[`TIG_DRV_CH1_BIT];
    assign line_out_neg_ch1_out      = neg_q[`TIG_DRV_CH1_BIT];
    assign line_out_pos_ch0_oe_b_out = oe_b_q[`TIG_DRV_CH0_BIT];
    assign line_out_neg_ch0_oe_b_out = oe_b_q[`TIG_DRV_CH0_BIT];
    assign line_out_pos_ch1_oe_b_out = oe_b_q[`TIG_DRV_CH1_BIT];
    assign line_out_neg_ch1_oe_b_out = oe_b_q[`TIG_DRV_CH1_BIT];
    // One cycle of latency trades for a glitch-free request
    assign irq_out                   = irq_q;

    // Checks; outputs are registered, so each answer lands one edge on

    // A switched-off channel 1 driver floats both legs
    a_drv1_off_tristate: assert property (@(posedge clk_in) // see R1
        disable iff (!rst_b_in)
        !drv_q[1] |=> line_out_pos_ch1_oe_b_out && line_out_neg_ch1_oe_b_out)
        else $error("ch1 driver not tri-stated");

    // A switched-off channel 0 driver floats both legs
    a_drv0_off_tristate: assert property (@(posedge clk_in) // see R2
        disable iff (!rst_b_in)
        !drv_q[0] |=> line_out_pos_ch0_oe_b_out && line_out_neg_ch0_oe_b_out)
        else $error("ch0 driver not tri-stated");

    // Register bit and synced pin together turn channel 0 on
    a_drv0_on_drives: assert property (@(posedge clk_in) // see R2
        disable iff (!rst_b_in)
        drv_q[0] && pin_s2_q[0]
        |=> !line_out_pos_ch0_oe_b_out && !line_out_neg_ch0_oe_b_out)
        else $error("ch0 driver not enabled");

    // A low pin overrides the register bit
    a_pin_low_off: assert property (@(posedge clk_in) // see R3
        disable iff (!rst_b_in)
        !pin_s2_q[1]
        |=> line_out_pos_ch1_oe_b_out && line_out_neg_ch1_oe_b_out)
        else $error("ch1 driven with pin low");

    // Back-to-back write and read returns the writable bits only
    a_ien_write_read: assert property (@(posedge clk_in) // see R4
        disable iff (!rst_b_in)
        wr_ien && !reg_req_in.rd ##1 rd_ien
        |=> reg_rdata_out == 8'($past(reg_req_in.wdata[NCH-1:0], 2)))
        else $error("block enable readback wrong");

    // All channels masked: the request line stays quiet
    a_ien_disable_quiet: assert property (@(posedge clk_in) // see R5
        disable iff (!rst_b_in)
        ien_q == '0 ##1 ien_q == '0 |-> !irq_out)
        else $error("irq with all channels disabled");

    // No pending bit without both enables
    a_src_gate_set: assert property (@(posedge clk_in) // see R6
        disable iff (!rst_b_in)
        !pend_q[0] && !(src_enable_in[0] && ien_q[0]) |=> !pend_q[0])
        else $error("pending set without both enables");

    // Channel 1 enable passes its own events
    a_chan_own_gate: assert property (@(posedge clk_in) // see R7
        disable iff (!rst_b_in)
        src_event_in[1] && src_enable_in[1] && ien_q[1] |=> pend_q[1])
        else $error("ch1 event lost");

    // Pending survives until its status read
    a_pend_sticky: assert property (@(posedge clk_in) // see R8
        disable iff (!rst_b_in)
        pend_q[0] && !src_status_read_in[0] |=> pend_q[0])
        else $error("pending dropped without read");

    // Request raised for any pending enabled channel
    a_irq_follow: assert property (@(posedge clk_in) // see R9
        disable iff (!rst_b_in)
        (pend_q & ien_q) != '0 |=> irq_out)
        else $error("irq missing");

    // Request dropped once nothing enabled is pending
    a_irq_clear: assert property (@(posedge clk_in) // see R9
        disable iff (!rst_b_in)
        (pend_q & ien_q) == '0 |=> !irq_out)
        else $error("irq stuck after clear");

    // Main scenarios worth seeing in a run
    c_drv_on: cover property (@(posedge clk_in)
        disable iff (!rst_b_in) !line_out_pos_ch1_oe_b_out);
    c_irq_raise: cover property (@(posedge clk_in)
        disable iff (!rst_b_in) $rose(irq_out));
    c_irq_fall: cover property (@(posedge clk_in)
        disable iff (!rst_b_in) $fell(irq_out));
    c_set_clear: cover property (@(posedge clk_in)
        disable iff (!rst_b_in) |(pend_set & src_status_read_in));
    c_ien_back2back: cover property (@(posedge clk_in)
        disable iff (!rst_b_in) wr_ien ##1 rd_ien);

endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "tig_consts.svh"
module tb_top
    import tig_pkg::*;
;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } tig_tb_row_t;

    logic         clk_in;
    logic         rst_b_in;
    tig_reg_req_t reg_req_in;
    logic [7:0]   reg_rdata_out;
    logic [1:0]   pin_en, tx_pos_in, tx_neg_in;
    logic [2:0]   src_event_in, src_enable_in, src_status_read_in;
    logic [3:0]   oe_b, ln;
    logic         irq_out;
    int           mismatches;
    int           checks_done;
    // Write then read back; unmapped and read-only places must read 0
    tig_tb_row_t  rows [5] = '{'{8'h20, 8'hff, 8'h07}, '{8'h01, 8'hff, 8'h03},
        '{8'h21, 8'hff, 8'h00}, '{8'h05, 8'hff, 8'h00},
        '{8'h20, 8'h00, 8'h00}};

    tig_top #(.NCH(3)) u_tig_top (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_req_in(reg_req_in),
        .reg_rdata_out(reg_rdata_out),
        .hw_driver_enable_pin_ch0_in(pin_en[0]),
        .hw_driver_enable_pin_ch1_in(pin_en[1]),
        .tx_pos_in(tx_pos_in), .tx_neg_in(tx_neg_in),
        .line_out_pos_ch0_out(ln[0]), .line_out_pos_ch0_oe_b_out(oe_b[0]),
        .line_out_neg_ch0_out(ln[1]), .line_out_neg_ch0_oe_b_out(oe_b[1]),
        .line_out_pos_ch1_out(ln[2]), .line_out_pos_ch1_oe_b_out(oe_b[2]),
        .line_out_neg_ch1_out(ln[3]), .line_out_neg_ch1_oe_b_out(oe_b[3]),
        .src_event_in(src_event_in), .src_enable_in(src_enable_in),
        .src_status_read_in(src_status_read_in), .irq_out(irq_out));

    // Free-running 40 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Launch on an edge, drop on the next: one-cycle strobe as required
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clk_in) reg_req_in <= '{wr: w, rd: ~w, addr: a, wdata: d};
        @(posedge clk_in) reg_req_in <= '0;
        #1;
    endtask

    task automatic ev(input logic [2:0] m);
        @(posedge clk_in) src_event_in <= m;
        @(posedge clk_in) src_event_in <= 3'h0;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        mismatches = 0;
        checks_done = 0;
        rst_b_in = 1'b0;
        reg_req_in = '0;
        pin_en = 2'h3;
        {tx_pos_in, tx_neg_in} = 4'h0;
        {src_event_in, src_enable_in, src_status_read_in} = 9'h0;
        cyc(5);
        rst_b_in <= 1'b0;
        @(posedge clk_in) rst_b_in <= 1'b1;
        #1;
        chk({3'h0, irq_out, oe_b}, 8'h0f);
        chk({4'h0, ln}, 8'h00);
        chk(reg_rdata_out, 8'h00);
        $display("test reset done");
        foreach (rows[i]) begin
            acc(1'b1, rows[i].addr, rows[i].wdata);
            acc(1'b0, rows[i].addr, 8'h00);
            chk(reg_rdata_out, rows[i].exp);
        end
        $display("test registers done");
        // Channel 1 on, channel 0 off; data must follow only on channel 1
        acc(1'b1, `TIG_ADDR_DRV_ON, 8'h02);
        @(posedge clk_in) begin
            tx_pos_in <= 2'h3;
            tx_neg_in <= 2'h3;
        end
        cyc(2);
        chk({4'h0, oe_b}, 8'h03);
        chk({4'h0, ln}, 8'h0c);
        @(posedge clk_in) pin_en <= 2'h1;
        cyc(4);
        chk({4'h0, oe_b}, 8'h0f);
        // Channel 0 on by register with its pin high: data must pass
        acc(1'b1, `TIG_ADDR_DRV_ON, 8'h01);
        cyc(2);
        chk({4'h0, oe_b}, 8'h0c);
        chk({4'h0, ln}, 8'h03);
        $display("test drivers done");
        // Block enables off: nothing may reach the request line
        @(posedge clk_in) src_enable_in <= 3'h7;
        ev(3'h7);
        cyc(3);
        chk({7'h0, irq_out}, 8'h00);
        acc(1'b1, `TIG_ADDR_BLK_IEN, 8'h01);
        ev(3'h2);
        cyc(3);
        chk({7'h0, irq_out}, 8'h00);
        ev(3'h1);
        cyc(2);
        chk({7'h0, irq_out}, 8'h01);
        acc(1'b0, `TIG_ADDR_BLK_ISTAT, 8'h00);
        chk(reg_rdata_out, 8'h01);
        cyc(3);
        chk({7'h0, irq_out}, 8'h01);
        @(posedge clk_in) src_status_read_in <= 3'h1;
        @(posedge clk_in) src_status_read_in <= 3'h0;
        cyc(3);
        chk({7'h0, irq_out}, 8'h00);
        @(posedge clk_in) src_enable_in <= 3'h0;
        ev(3'h1);
        cyc(3);
        chk({7'h0, irq_out}, 8'h00);
        $display("test interrupts done");
        // Write then read on the next edge; only channels 2 and 1 enabled
        @(posedge clk_in) src_enable_in <= 3'h7;
        @(posedge clk_in) reg_req_in <= '{1'b1, 1'b0, 8'h20, 8'hfe};
        @(posedge clk_in) reg_req_in <= '{1'b0, 1'b1, 8'h20, 8'h00};
        @(posedge clk_in) reg_req_in <= '0;
        #1;
        chk(reg_rdata_out, 8'h06);
        ev(3'h1);
        cyc(2);
        chk({7'h0, irq_out}, 8'h00);
        ev(3'h2);
        cyc(2);
        chk({7'h0, irq_out}, 8'h01);
        acc(1'b0, `TIG_ADDR_BLK_ISTAT, 8'h00);
        chk(reg_rdata_out, 8'h02);
        // Event and status read in one cycle: the event must win
        @(posedge clk_in) begin
            src_event_in       <= 3'h2;
            src_status_read_in <= 3'h2;
        end
        @(posedge clk_in) begin
            src_event_in       <= 3'h0;
            src_status_read_in <= 3'h0;
        end
        cyc(2);
        chk({7'h0, irq_out}, 8'h01);
        @(posedge clk_in) src_status_read_in <= 3'h2;
        @(posedge clk_in) src_status_read_in <= 3'h0;
        cyc(3);
        chk({7'h0, irq_out}, 8'h00);
        $display("test back to back done");
        // Mid-run reset clears the enables again
        @(posedge clk_in) rst_b_in <= 1'b0;
        @(posedge clk_in) rst_b_in <= 1'b1;
        acc(1'b0, `TIG_ADDR_BLK_IEN, 8'h00);
        chk(reg_rdata_out, `TIG_BLK_IEN_RST);
        $display("test second reset done");
        print_verdict();
    end
endmodule
